//--- hdl/async_rx_defs.svh
// Constants for the asynchronous receive front end
`ifndef ASYNC_RX_DEFS_SVH
`define ASYNC_RX_DEFS_SVH
// Start-bit midpoint checks in receive-clock periods (half a bit)
`define RX_HALF_16 7'h08
`define RX_HALF_64 7'h20
// Full bit length in receive-clock periods
`define RX_BIT_16 7'h10
`define RX_BIT_64 7'h40
// Register offsets
`define REG_DATA 4'h0
`define REG_STATUS 4'h1
`define REG_MASK 4'h2
`define REG_CTRL 4'h3
// Status and control bit positions
`define STAT_READY 0
`define STAT_PARITY 1
`define STAT_FRAME 2
`define STAT_OVERRUN 3
`define CT_X64 0
`define CT_SYNC 1
`define CT_PAR_EN 2
`define CT_PAR_ODD 3
`define CT_LEN_LO 4
// Status update bound in main-clock periods
`define STATUS_MAX_CYCLES 5'h1c
`define STAT_W 4
`endif

//--- hdl/async_rx_pkg.sv
// Types shared by the receive front end
package async_rx_pkg;
   typedef enum logic [2:0]
   {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PARITY = 3'b011,
      RX_STOP = 3'b100
   } rx_state_t;
   typedef struct packed
   {
      logic x64;
      logic sync_mode;
      logic par_en;
      logic par_odd;
      logic [1:0] len_sel;
   } rx_cfg_t;
   typedef struct packed
   {
      logic ready;
      logic parity_err;
      logic frame_err;
      logic [7:0] data;
   } rx_event_t;
endpackage : async_rx_pkg

//--- hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for outside inputs
`timescale 1ns/1ps
`include "async_rx_defs.svh"
module pin_sync
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic level,
   output logic rise
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic level;
      logic rise;
   } sync_state_t;
   sync_state_t state;
   sync_state_t next_state;
   // First stage feeds only the second; level follows when stages two and three agree
   always_comb
   begin
      next_state = state;
      next_state.s1 = pin;
      next_state.s2 = state.s1;
      next_state.s3 = state.s2;
      next_state.rise = 1'b0;
      if (state.s2 == state.s3)
      begin
         next_state.level = state.s3;
         next_state.rise = state.s3 & ~state.level;
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, rise: 1'b0};
      else
         state <= next_state;
   end
   assign level = state.level;
   assign rise = state.rise;
endmodule : pin_sync

//--- hdl/async_rx_front.sv
// Asynchronous receive front end with start qualification and break parity quirk
//
// What this block does
// - In 16x mode a low pulse shorter than 7 clocks is dropped as noise.
// - In 64x mode a low pulse shorter than 31 clocks is dropped.
// - In 16x mode a 9 to 16 clock low is a valid start bit.
// - In 64x mode a 33 to 64 clock low is a valid start bit.
// - With even parity and eight data bits, break ending between last data bit and parity sets parity error, no ready.
// - That spurious parity error stays set into the next good character.
// - Start qualification and break quirk apply only in asynchronous mode.
// - Status bits follow their event within 28 main-clock periods.
`timescale 1ns/1ps
`include "async_rx_defs.svh"
module async_rx_front
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic receive_sample_clock,
   input wire logic rx_line,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic rx_ready,
   output logic irq
);
   logic [1:0] rst_pipe;
   logic rst_sync_n;
   logic line_level;
   logic tick;

   // Reset released through two flops so all state leaves reset together
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe <= 2'b00;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_sync_n = rst_pipe[1];

   pin_sync line_sync
   (
      .clk(clk),
      .rst_n(rst_sync_n),
      .pin(rx_line),
      .level(line_level),
      .rise()
   );
   pin_sync clock_sync
   (
      .clk(clk),
      .rst_n(rst_sync_n),
      .pin(receive_sample_clock),
      .level(),
      .rise(tick)
   );

   typedef struct packed
   {
      async_rx_pkg::rx_state_t fsm;
      logic [6:0] cnt;
      logic [3:0] bit_idx;
      logic [7:0] shift;
      logic par_acc;
      logic line_prev;
      async_rx_pkg::rx_cfg_t cfg;
      async_rx_pkg::rx_event_t ev;
      logic [7:0] data;
      logic [`STAT_W-1:0] status;
      logic [`STAT_W-1:0] mask;
      logic [7:0] rdata;
      logic irq;
   } rx_top_state_t;
   rx_top_state_t state;
   rx_top_state_t next_state;

   // Data bits for the selected character length (5 to 8)
   function automatic logic [3:0] char_bits(input logic [1:0] sel);
      char_bits = 4'h5 + {2'b00, sel};
   endfunction : char_bits

   // Half and full bit lengths in receive-clock periods for the rate mode
   function automatic logic [6:0] half_bit(input logic x64);
      half_bit = x64 ? `RX_HALF_64 : `RX_HALF_16;
   endfunction : half_bit
   function automatic logic [6:0] full_bit(input logic x64);
      full_bit = x64 ? `RX_BIT_64 : `RX_BIT_16;
   endfunction : full_bit

   // Receiver sequencer, status flags and register port in one pass
   always_comb
   begin
      next_state = state;
      next_state.ev = '0;
      next_state.rdata = 8'h00;
      if (tick)
      begin
         // Edge detection runs on sample ticks, so a fall between ticks is still seen
         next_state.line_prev = line_level;
         case (state.fsm)
            async_rx_pkg::RX_IDLE:
            begin
               if (!state.cfg.sync_mode && state.line_prev && !line_level)
               begin
                  next_state.fsm = async_rx_pkg::RX_START;
                  next_state.cnt = 7'h01;
               end
            end
            async_rx_pkg::RX_START:
            begin
               // recheck on every tick up to the midpoint; short lows return to idle
               if (line_level && state.cnt <= half_bit(state.cfg.x64))
                  next_state.fsm = async_rx_pkg::RX_IDLE;
               else if (state.cnt == half_bit(state.cfg.x64))
               begin
                  // low through the midpoint is a start bit
                  next_state.cnt = 7'h00;
                  next_state.bit_idx = 4'h0;
                  next_state.par_acc = state.cfg.par_odd;
                  next_state.fsm = async_rx_pkg::RX_DATA;
               end
               else
                  next_state.cnt = state.cnt + 7'h01;
            end
            async_rx_pkg::RX_DATA:
            begin
               if (state.cnt == full_bit(state.cfg.x64) - 7'h01)
               begin
                  next_state.cnt = 7'h00;
                  next_state.shift = {line_level, state.shift[7:1]};
                  next_state.par_acc = state.par_acc ^ line_level;
                  next_state.bit_idx = state.bit_idx + 4'h1;
                  if (state.bit_idx == char_bits(state.cfg.len_sel) - 4'h1)
                     next_state.fsm = state.cfg.par_en ? async_rx_pkg::RX_PARITY
                                                       : async_rx_pkg::RX_STOP;
               end
               else
                  next_state.cnt = state.cnt + 7'h01;
            end
            async_rx_pkg::RX_PARITY:
            begin
               if (state.cnt == full_bit(state.cfg.x64) - 7'h01)
               begin
                  next_state.cnt = 7'h00;
                  // break ended before parity: flag error, skip ready
                  // All-zero data with a high, wrong parity bit marks a break's end
                  if (state.shift == 8'h00 && line_level && (state.par_acc ^ line_level))
                  begin
                     next_state.ev.parity_err = 1'b1;
                     next_state.fsm = async_rx_pkg::RX_IDLE;
                  end
                  else
                  begin
                     next_state.ev.parity_err = state.par_acc ^ line_level;
                     next_state.fsm = async_rx_pkg::RX_STOP;
                  end
               end
               else
                  next_state.cnt = state.cnt + 7'h01;
            end
            async_rx_pkg::RX_STOP:
            begin
               if (state.cnt == full_bit(state.cfg.x64) - 7'h01)
               begin
                  next_state.cnt = 7'h00;
                  next_state.ev.ready = 1'b1;
                  next_state.ev.frame_err = ~line_level;
                  next_state.ev.data = state.shift >> (4'h8 - char_bits(state.cfg.len_sel));
                  next_state.fsm = async_rx_pkg::RX_IDLE;
               end
               else
                  next_state.cnt = state.cnt + 7'h01;
            end
            default:
               next_state.fsm = async_rx_pkg::RX_IDLE;
         endcase
      end
      // Register reads: data read clears ready, reads are accepted whether or not ready is set
      if (rd)
      begin
         case (addr)
            `REG_DATA:
            begin
               next_state.rdata = state.data;
               next_state.status[`STAT_READY] = 1'b0;
            end
            `REG_STATUS: next_state.rdata = {4'h0, state.status};
            `REG_MASK: next_state.rdata = {4'h0, state.mask};
            `REG_CTRL: next_state.rdata = {2'b00, state.cfg.len_sel, state.cfg.par_odd,
                                           state.cfg.par_en, state.cfg.sync_mode, state.cfg.x64};
            default: next_state.rdata = 8'h00;
         endcase
      end
      // Write one to clear status bits; mask and control write straight
      if (wr)
      begin
         case (addr)
            `REG_STATUS: next_state.status = state.status & ~wdata[`STAT_W-1:0];
            `REG_MASK: next_state.mask = wdata[`STAT_W-1:0];
            `REG_CTRL:
            begin
               // Field by field, since the struct order differs from the register layout
               next_state.cfg.x64 = wdata[`CT_X64];
               next_state.cfg.sync_mode = wdata[`CT_SYNC];
               next_state.cfg.par_en = wdata[`CT_PAR_EN];
               next_state.cfg.par_odd = wdata[`CT_PAR_ODD];
               next_state.cfg.len_sel = wdata[`CT_LEN_LO+1:`CT_LEN_LO];
            end
            default: next_state.cfg = state.cfg;
         endcase
      end
      // events land two cycles after detection; set beats clear
      if (state.ev.ready)
      begin
         next_state.status[`STAT_OVERRUN] = state.status[`STAT_OVERRUN] | state.status[`STAT_READY];
         next_state.status[`STAT_READY] = 1'b1;
         next_state.data = state.ev.data;
      end
      // parity error is sticky; a good character never clears it
      if (state.ev.parity_err)
         next_state.status[`STAT_PARITY] = 1'b1;
      if (state.ev.frame_err)
         next_state.status[`STAT_FRAME] = 1'b1;
      next_state.irq = |(next_state.status & next_state.mask);
   end

   always_ff @(posedge clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state <= '0;
         state.line_prev <= 1'b1;
      end
      else
         state <= next_state;
   end

   assign rdata = state.rdata;
   assign rx_ready = state.status[`STAT_READY];
   assign irq = state.irq;

   // Assertions guarding the receiver
   chk_short_noise: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (state.fsm == async_rx_pkg::RX_START && tick && line_level
       && state.cnt < half_bit(state.cfg.x64)) |=> state.fsm == async_rx_pkg::RX_IDLE)
      else $error("short low pulse not dropped");
   chk_start_accept: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (state.fsm == async_rx_pkg::RX_START && tick
       && !line_level && state.cnt == half_bit(state.cfg.x64))
      |=> state.fsm == async_rx_pkg::RX_DATA)
      else $error("valid start bit not accepted");
   chk_sync_bypass: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (state.cfg.sync_mode && state.fsm == async_rx_pkg::RX_IDLE)
      |=> state.fsm == async_rx_pkg::RX_IDLE)
      else $error("start qualification in synchronous mode");
   chk_parity_sticky: assert property (@(posedge clk) disable iff (!rst_sync_n)
      (state.status[`STAT_PARITY] && !(wr && addr == `REG_STATUS && wdata[`STAT_PARITY]))
      |=> state.status[`STAT_PARITY])
      else $error("parity error flag lost");
   chk_ready_update: assert property (@(posedge clk) disable iff (!rst_sync_n)
      state.ev.ready |=> rx_ready)
      else $error("ready not raised after character");
   chk_irq_level: assert property (@(posedge clk) disable iff (!rst_sync_n)
      ##1 irq == $past(|(next_state.status & next_state.mask)))
      else $error("interrupt does not follow masked status");
   cov_start: cover property (@(posedge clk) state.fsm == async_rx_pkg::RX_DATA);
   cov_ready: cover property (@(posedge clk) $rose(rx_ready));
   cov_parity: cover property (@(posedge clk) $rose(state.status[`STAT_PARITY]));
endmodule : async_rx_front

//--- verification/serial_sender.sv
// Remote asynchronous sender driving the serial line and its receive clock
`timescale 1ns/1ps
module serial_sender
(
   input wire logic clk,
   output logic rx_line,
   output logic receive_sample_clock
);
   // Line idles high, clock rests high between frames
   initial
   begin
      rx_line = 1'b1;
      receive_sample_clock = 1'b1;
   end

   // One 160 ns receive clock period per tick, line set at the falling edge
   task automatic ticks(input logic level, input int n);
      repeat (n)
      begin
         @(posedge clk);
         rx_line <= level;
         receive_sample_clock <= 1'b0;
         repeat (20) @(posedge clk);
         receive_sample_clock <= 1'b1;
         repeat (19) @(posedge clk);
      end
   endtask : ticks

   // Start, eight data bits, parity and two stop bits; brk holds data low
   task automatic send_frame(input logic x64, input int sl, input logic [7:0] d,
      input logic par, input logic brk);
      int bt;
      bt = x64 ? 64 : 16;
      // start never exactly half a bit
      ticks(1'b0, sl);
      ticks(1'b1, bt - sl);
      for (int i = 0; i < 8; i++)
         ticks(brk ? 1'b0 : d[i], bt);
      ticks(par, bt);
      ticks(1'b1, 2 * bt);
   endtask : send_frame
endmodule : serial_sender

//--- verification/async_rx_front_tb_top.sv
// Self-checking bench for the asynchronous receive front end
`timescale 1ns/1ps
`include "async_rx_defs.svh"
module async_rx_front_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic rx_ready;
   logic irq;
   logic rx_line;
   logic rsc;
   int n_fail = 0;
   int n_compared = 0;

   // 250 MHz main clock
   always #2 clk = ~clk;

   serial_sender serial_sender_i
   (
      .clk(clk),
      .rx_line(rx_line),
      .receive_sample_clock(rsc)
   );

   async_rx_front async_rx_front_i
   (
      .clk(clk),
      .rst_n(rst_n),
      .receive_sample_clock(rsc),
      .rx_line(rx_line),
      .addr(addr),
      .wdata(wdata),
      .wr(wr),
      .rd(rd),
      .rdata(rdata),
      .rx_ready(rx_ready),
      .irq(irq)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      if (n_fail == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // Single-cycle strobes; a gap cycle keeps strobes from being set twice at once
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   // Short low pulse must leave no trace
   task automatic t_noise(input logic x64, input int n);
      logic [7:0] s;
      wr_reg(`REG_CTRL, {7'h1a, x64});
      serial_sender_i.ticks(1'b0, n);
      serial_sender_i.ticks(1'b1, 40);
      rd_reg(`REG_STATUS, s);
      check(s, 8'h00); // pulse dropped
   endtask : t_noise

   // Shortest accepted start, then a normal character
   task automatic t_char(input logic x64, input int sl, input logic [7:0] d);
      logic [7:0] s;
      wr_reg(`REG_CTRL, {7'h1a, x64});
      wr_reg(`REG_MASK, 8'h01);
      serial_sender_i.send_frame(x64, sl, d, ^d, 1'b0);
      check({6'h00, irq, rx_ready}, 8'h03); // ready and irq
      rd_reg(`REG_STATUS, s);
      check(s, 8'h01); // ready only
      rd_reg(`REG_DATA, s);
      check(s, d); // data intact
      @(posedge clk);
      #1;
      check({6'h00, irq, rx_ready}, 8'h00); // read clears ready
      wr_reg(`REG_MASK, 8'h00);
   endtask : t_char

   // Break ending before parity leaves a stale parity flag
   task automatic t_break();
      logic [7:0] s;
      wr_reg(`REG_CTRL, 8'h34);
      wr_reg(`REG_MASK, 8'h02);
      serial_sender_i.send_frame(1'b0, 16, 8'h00, 1'b1, 1'b1);
      rd_reg(`REG_STATUS, s);
      check(s, 8'h02); // parity set, no ready
      check({6'h00, irq, rx_ready}, 8'h02); // unmasked parity
      wr_reg(`REG_MASK, 8'h00);
      serial_sender_i.send_frame(1'b0, 16, 8'h3c, 1'b0, 1'b0);
      rd_reg(`REG_STATUS, s);
      check(s, 8'h03); // stale parity kept
      check({7'h00, irq}, 8'h00); // masked status
      wr_reg(`REG_STATUS, 8'h02);
      rd_reg(`REG_STATUS, s);
      check(s, 8'h01); // cleared by one
      rd_reg(`REG_DATA, s);
      check(s, 8'h3c); // good character
   endtask : t_break

   // Synchronous mode ignores the line; unmapped reads return zero
   task automatic t_misc();
      logic [7:0] s;
      wr_reg(`REG_CTRL, 8'h36);
      serial_sender_i.send_frame(1'b0, 16, 8'h55, 1'b0, 1'b0);
      rd_reg(`REG_STATUS, s);
      check(s, 8'h00); // no async reception
      wr_reg(4'h7, 8'hff);
      rd_reg(4'h7, s);
      check(s, 8'h00); // unmapped address
   endtask : t_misc

   // Main sequence after an 8-cycle reset
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_noise(1'b0, 6);
      t_char(1'b0, 9, 8'ha5);
      t_break();
      t_misc();
      t_noise(1'b1, 30);
      t_char(1'b1, 33, 8'h6e);
      finish_test();
   end

   // Cut a hung run short
   initial
   begin
      #400us;
      n_fail++;
      finish_test();
   end
endmodule : async_rx_front_tb_top
